// >>> rtl/pisosh_pkg.sv
package pisosh_pkg;

   localparam int unsigned PISOSH_STAGES = 8;
   localparam int unsigned PISOSH_SYNC_DEPTH = 3;
   localparam logic [7:0] PISOSH_STAGE_RST = 8'h00;
   localparam logic [2:0] PISOSH_SYNC_RST = 3'h0;
   localparam int unsigned PISOSH_CTRL_PINS = 4;
   localparam int unsigned PISOSH_SER_POS = 0;
   localparam int unsigned PISOSH_GATE_POS = 1;
   localparam int unsigned PISOSH_CLK_POS = 2;
   localparam int unsigned PISOSH_SEL_POS = 3;
   localparam int unsigned PISOSH_PAR_POS = 4;

endpackage : pisosh_pkg

// >>> rtl/pisosh_sync.sv
`timescale 1ns/1ps
module pisosh_sync
   import pisosh_pkg::*;
#(
   parameter int unsigned WIDTH = 1
) (
   input  wire logic             mclk_i,
   input  wire logic             srst_i,
   input  wire logic [WIDTH-1:0] async_i,
   output logic      [WIDTH-1:0] level_o
);

   typedef struct packed {
      logic [WIDTH-1:0] s1;
      logic [WIDTH-1:0] s2;
      logic [WIDTH-1:0] s3;
      logic [WIDTH-1:0] lvl;
   } pisosh_sync_st_t;

   pisosh_sync_st_t st_r;
   pisosh_sync_st_t st_nxt;

   ////////////////////////////////////////////////////////////////////////
   // three stages, change taken when stages two and three agree
   always_comb begin
      st_nxt     = st_r;
      st_nxt.s1  = async_i;
      st_nxt.s2  = st_r.s1;
      st_nxt.s3  = st_r.s2;
      for (int i = 0; i < int'(WIDTH); i++) begin
         if (st_r.s2[i] == st_r.s3[i]) begin
            st_nxt.lvl[i] = st_r.s3[i];
         end
      end
   end

   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign level_o = st_r.lvl;

endmodule : pisosh_sync

// >>> rtl/pisosh_top.sv
// Behaviour
// - eight stages shift toward last stage
// - eight parallel inputs load while select low
// - select low: stages follow parallel inputs
// - clock rise with gate low shifts once
// - gate rise with clock low shifts once
// - either input high holds the stages
// - inverted serial output always provided
// - select high ignores parallel inputs
`timescale 1ns/1ps
module pisosh_top
   import pisosh_pkg::*;
#(
   parameter int unsigned STAGES = PISOSH_STAGES
) (
   input  wire logic              mclk_i,
   input  wire logic              srst_i,
   input  wire logic [STAGES-1:0] parallel_data_i,
   input  wire logic              shift_load_select_i,
   input  wire logic              shift_clock_i,
   input  wire logic              clock_gate_input_i,
   input  wire logic              serial_in_i,
   output logic                   serial_out_o,
   output logic                   serial_out_n_o
);

   ////////////////////////////////////////////////////////////////////////
   // local sizes and pin positions
   localparam int unsigned SW     = STAGES + PISOSH_CTRL_PINS;
   localparam int unsigned LAST   = STAGES - 1;
   localparam int unsigned PAR_LO = PISOSH_PAR_POS;

   ////////////////////////////////////////////////////////////////////////
   // operation picked for the stages each cycle
   typedef enum logic [2:0] {
      PISOSH_OP_LOAD  = 3'h1,
      PISOSH_OP_SHIFT = 3'h2,
      PISOSH_OP_HOLD  = 3'h4
   } pisosh_op_t;

   ////////////////////////////////////////////////////////////////////////
   // registered state
   typedef struct packed {
      logic [STAGES-1:0] stage;
      logic              clk_d;
      logic              gate_d;
      logic              q;
      logic              qn;
   } pisosh_st_t;

   ////////////////////////////////////////////////////////////////////////
   // internal nets
   pisosh_st_t        st_r;
   pisosh_st_t        st_nxt;

   logic [SW-1:0]     sync_in;
   logic [SW-1:0]     sync_lvl;
   logic [STAGES-1:0] par_s;
   logic              sel_s;
   logic              clk_s;
   logic              gate_s;
   logic              ser_s;

   logic              clk_rise;
   logic              gate_rise;
   logic              shift_ev;
   pisosh_op_t        op;
   logic [STAGES-1:0] stage_nxt;

   ////////////////////////////////////////////////////////////////////////
   // one pin level out of the synchronised vector
   function automatic logic pin_at(
      input logic [SW-1:0] vec,
      input int unsigned   pos
   );
      pin_at = vec[pos];
   endfunction : pin_at

   ////////////////////////////////////////////////////////////////////////
   // rise of one timing input while the other is low
   function automatic logic lone_rise(
      input logic now_lvl,
      input logic prev_lvl,
      input logic other_now,
      input logic other_prev
   );
      lone_rise = now_lvl && !prev_lvl && !other_now && !other_prev;
   endfunction : lone_rise

   ////////////////////////////////////////////////////////////////////////
   // operation from select level and shift event
   function automatic pisosh_op_t op_decode(
      input logic sel,
      input logic ev
   );
      if (!sel) begin
         op_decode = PISOSH_OP_LOAD;
      end else if (ev) begin
         op_decode = PISOSH_OP_SHIFT;
      end else begin
         op_decode = PISOSH_OP_HOLD;
      end
   endfunction : op_decode

   ////////////////////////////////////////////////////////////////////////
   // next value of one stage for an operation
   function automatic logic stage_pick(
      input pisosh_op_t opv,
      input logic       par_bit,
      input logic       lower_bit,
      input logic       own_bit
   );
      case (opv)
         PISOSH_OP_LOAD: begin
            stage_pick = par_bit;
         end

         PISOSH_OP_SHIFT: begin
            stage_pick = lower_bit;
         end

         default: begin
            stage_pick = own_bit;
         end
      endcase
   endfunction : stage_pick

   ////////////////////////////////////////////////////////////////////////
   // pins gathered for synchronising
   assign sync_in = {
      parallel_data_i,
      shift_load_select_i,
      shift_clock_i,
      clock_gate_input_i,
      serial_in_i
   };

   ////////////////////////////////////////////////////////////////////////
   // pin synchronisers
   pisosh_sync #(
      .WIDTH (SW)
   ) u_sync (
      .mclk_i  (mclk_i),
      .srst_i  (srst_i),
      .async_i (sync_in),
      .level_o (sync_lvl)
   );

   ////////////////////////////////////////////////////////////////////////
   // pin levels
   for (genvar p = 0; p < int'(STAGES); p++) begin : g_par
      // parallel bit p to stage p
      assign par_s[p] = pin_at(sync_lvl, PAR_LO + p);
   end

   assign sel_s  = pin_at(sync_lvl, PISOSH_SEL_POS);
   assign clk_s  = pin_at(sync_lvl, PISOSH_CLK_POS);
   assign gate_s = pin_at(sync_lvl, PISOSH_GATE_POS);
   assign ser_s  = pin_at(sync_lvl, PISOSH_SER_POS);

   ////////////////////////////////////////////////////////////////////////
   // shift event detection
   // clock rising edge
   assign clk_rise  = lone_rise(clk_s, st_r.clk_d, gate_s, st_r.gate_d);

   assign gate_rise = lone_rise(gate_s, st_r.gate_d, clk_s, st_r.clk_d);

   assign shift_ev  = clk_rise || gate_rise;

   assign op = op_decode(sel_s, shift_ev);

   ////////////////////////////////////////////////////////////////////////
   // per-stage next value
   for (genvar g = 0; g < int'(STAGES); g++) begin : g_stage
      if (g == 0) begin : g_first
         assign stage_nxt[g] = stage_pick(op, par_s[g], ser_s, st_r.stage[g]);
      end else begin : g_rest
         assign stage_nxt[g] = stage_pick(op, par_s[g], st_r.stage[g-1], st_r.stage[g]);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // next state
   always_comb begin
      st_nxt        = st_r;
      st_nxt.clk_d  = clk_s;
      st_nxt.gate_d = gate_s;
      st_nxt.stage  = stage_nxt;
      st_nxt.q      = stage_nxt[LAST];
      st_nxt.qn     = ~stage_nxt[LAST];
   end

   ////////////////////////////////////////////////////////////////////////
   // state register
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         st_r       <= '0;
         st_r.stage <= STAGES'(PISOSH_STAGE_RST);
         st_r.qn    <= 1'b1;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign serial_out_o   = st_r.q;
   assign serial_out_n_o = st_r.qn;

endmodule : pisosh_top

// >>> tb/pisosh_top_asserts.sv
`timescale 1ns/1ps
module pisosh_top_asserts(
input wire logic mclk_i,srst_i,shift_load_select_i,shift_clock_i,clock_gate_input_i,
input wire logic serial_out_o,serial_out_n_o,input wire logic [7:0] parallel_data_i);
wire sel=shift_load_select_i,ck=shift_clock_i,gt=clock_gate_input_i,so=serial_out_o;
wire [7:0] d=parallel_data_i;
default clocking @(posedge mclk_i); endclocking
default disable iff (srst_i);
a_out_inv: assert property (serial_out_n_o!=so) else $error("inv");
a_load_last: assert property ((!sel&&$stable(d))[*6] |-> so==d[7]) else $error("ld");
a_hold_high: assert property ((sel&&(ck||gt))[*8] |-> $stable(so)) else $error("hi");
a_hold_idle: assert property ((sel&&!ck&&!gt)[*8] |-> $stable(so)) else $error("id");
a_shift_cause: assert property (sel[*8] ##0 $changed(so) |->
$past(ck,3)&&!$past(ck,6)||$past(gt,3)&&!$past(gt,6)) else $error("sc");
a_one_step: assert property (sel[*8] ##0 $changed(so) |=> $stable(so)[*3]) else $error("x2");
a_load_cause: assert property (!sel[*8] ##0 $changed(so) |->
$past(d[7],3)!=$past(d[7],6)) else $error("lc");
a_gate_inhibit: assert property ((sel&&ck)[*6] ##1 (sel&&ck&&$rose(gt)) |->
$stable(so)[*6]) else $error("gi");
endmodule:pisosh_top_asserts

// >>> tb/pisosh_ctl.sv
`timescale 1ns/1ps
module pisosh_ctl(input wire logic mclk_i,output logic clk_o=0,gate_o=0);
// one rise of clock or gate
task automatic step(input bit g);
repeat(4) @(negedge mclk_i); if(g) gate_o=1; else clk_o=1;
repeat(4) @(negedge mclk_i); {clk_o,gate_o}=0;
endtask:step
task automatic hold();
repeat(4) @(negedge mclk_i);
clk_o=1; repeat(6) @(negedge mclk_i); gate_o=1; repeat(6) @(negedge mclk_i);
clk_o=0; repeat(6) @(negedge mclk_i); gate_o=0;
endtask:hold
endmodule:pisosh_ctl

// >>> tb/pisosh_top_tb.sv
`timescale 1ns/1ps
bind pisosh_top pisosh_top_asserts u_chk(.*);
module pisosh_top_tb;
logic mclk_i=0,srst_i=1,sel=0,sin=0,ck,gt,so,son,e;
logic [7:0] d=0,sv;
int seed=12,n_fail=0,n_checks=0;
logic q[$];
event shot;
always #4 mclk_i=~mclk_i;
pisosh_ctl u_ctl(.mclk_i,.clk_o(ck),.gate_o(gt));
pisosh_top uut(.mclk_i,.srst_i,.parallel_data_i(d),.shift_load_select_i(sel),.shift_clock_i(ck),
.clock_gate_input_i(gt),.serial_in_i(sin),.serial_out_o(so),.serial_out_n_o(son));
task automatic chk(input logic [1:0] s,x);
n_checks++;
if(s!==x) begin n_fail++; $display("[FAIL] sout exp %b got %b",x,s); end
endtask:chk
task automatic summarize();
$display("checks %0d fails %0d",n_checks,n_fail);
if(n_fail==0&&n_checks>0) $display("NO MISMATCHES");
else $display("MISMATCHES SEEN");
$finish;
endtask:summarize
task automatic note(input logic x);
q.push_back(x); repeat(3) @(negedge mclk_i); ->shot;
endtask:note
always @shot begin
e=q.pop_front();
chk({so,son},{e,!e});
end
initial begin
#20us; n_fail++; summarize();
end
initial begin
repeat(5) @(negedge mclk_i); srst_i=0;
for(int i=0;i<3;i++) begin
sel=0; d=8'($random(seed)); u_ctl.step(i[0]); // timing pins moved while loading
d=8'($random(seed)); repeat(6) @(negedge mclk_i); note(d[7]); sv=d;
sel=1; repeat(4) @(negedge mclk_i); d=8'($random(seed));
for(int k=0;k<9;k++) begin
sin=1'($random(seed)); sv={sv[6:0],sin};
if(k==4) u_ctl.hold(); else u_ctl.step(k[0]);
note(sv[7]);
end
$display("round %0d done",i);
end
summarize();
end
endmodule:pisosh_top_tb
